/* File: adsp_spi_port.sv */
/*
  Serial register port of the analog die: 16-bit frames, slave side.
  Assumes the select, shift clock and data pins are asynchronous to clk_in and
  that the shift clock runs well below a quarter of clk_in.
*/
// How it works
// - A frame is a command byte then a data byte in; status then data out.
// - Select falling starts a frame and turns the data output on.
// - The first output bit appears at the first rising shift clock edge.
// - Output data changes only on rising shift clock edges.
// - Incoming data is sampled on falling shift clock edges.
// - A frame counts only with exactly sixteen sampling edges.
// - Write data is accepted at the rising select edge ending the frame; it reaches its register when it drains from the FIFO.
// - Addressed register is loaded for output while the parity bit is sent.
// - While select is high the data output is released.
// - Command byte holds a five-bit address and a direction flag.
// - Direction one reads: second input byte ignored, register returned.
// - Direction zero writes: old register value returned meanwhile.
// - Parity is checked on writes only.
// - The first output byte is always the system status register.
// - Registers 0x00 to 0x11 are reachable, eight bits each.
// - Watchdog clear pulses one cycle after that write drains from the FIFO into the registers.
`timescale 1ns/1ns
module adsp_spi_port
  import adsp_pkg::*;
#(
  parameter int NREG       = adsp_pkg::ADSP_NREG,
  parameter int FIFO_DEPTH = adsp_pkg::ADSP_FIFO_DEPTH
) (
  input  wire logic                       clk_in,
  input  wire logic                       resetn_in,
  input  wire logic                       select_n_in,
  input  wire logic                       serial_shift_clock_in,
  input  wire logic                       mosi_in,
  output logic                            miso_out,
  output logic                            miso_oe_n_out,
  input  wire logic [NREG-1:0][7:0]       hw_status_in,
  input  wire logic                       reg_hold_in,
  output logic [NREG-1:0][7:0]            reg_file_out,
  output logic                            watchdog_clear_out,
  output logic                            frame_error_out
);
  import adsp_pkg::*;

  // Read value of one register: stored bits merged with live core bits.
  function automatic logic [7:0] rd_value(input logic [4:0] a,
                                           input logic [NREG-1:0][7:0] r,
                                           input logic [NREG-1:0][7:0] hw);
    logic [7:0] v;
    v = 8'h00;
    if (a < 5'(NREG)) begin
      v = (r[a] & ADSP_RD_MASK[a]) | (hw[a] & ADSP_HW_MASK[a]);
    end
    return v;
  endfunction : rd_value

  // A synchronised pin changes its filtered level once stages two and three agree.
  function automatic logic agreed(input logic s2, input logic s3, input logic f);
    return (s2 == s3) ? s3 : f;
  endfunction : agreed

  logic [2:0]        sync1;
  logic [2:0]        sync2;
  logic [2:0]        sync3;
  logic [2:0]        filt;
  logic [2:0]        next_filt;
  logic              ss_fall;
  logic              ss_rise;
  logic              sck_rise;
  logic              sck_fall;
  logic              mosi_lvl;

  adsp_state_t       state;
  logic [15:0]       rx_word;
  logic [4:0]        rx_cnt;
  logic [4:0]        rise_cnt;
  logic [15:0]       tx_word;
  logic              wr_pend;
  adsp_wr_t          wr_cmd;
  logic              write_ok;
  logic [NREG-1:0][7:0] regs;

  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  adsp_wr_t          fifo_out_data;
  logic              drain;

  // Bit order of the sync vectors: 2 = select, 1 = shift clock, 0 = data.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1 <= 3'h4;
      sync2 <= 3'h4;
      sync3 <= 3'h4;
    end else begin
      sync1 <= {select_n_in, serial_shift_clock_in, mosi_in};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_filt[i] = agreed(sync2[i], sync3[i], filt[i]);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      filt <= 3'h4;
    end else begin
      filt <= next_filt;
    end
  end

  assign ss_fall  = filt[2] && !next_filt[2];
  assign ss_rise  = !filt[2] && next_filt[2];
  assign sck_rise = !filt[1] && next_filt[1] && !next_filt[2];
  assign sck_fall = filt[1] && !next_filt[1] && !next_filt[2];
  assign mosi_lvl = next_filt[0];

  // Frame framing and the output enable.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state         <= ADSP_IDLE;
      miso_oe_n_out <= 1'b1;
    end else begin
      case (state)
        ADSP_IDLE: begin
          if (ss_fall) begin
            state         <= ADSP_ACTIVE;
            miso_oe_n_out <= 1'b0;
          end
        end
        ADSP_ACTIVE: begin
          if (ss_rise) begin
            state         <= ADSP_IDLE;
            miso_oe_n_out <= 1'b1;
          end
        end
        default: begin
          state         <= ADSP_IDLE;
          miso_oe_n_out <= 1'b1;
        end
      endcase
    end
  end

  // Receive shifter; the count saturates so that extra edges stay visible.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_word <= 16'h0000;
      rx_cnt  <= 5'h00;
    end else if (ss_fall) begin
      rx_cnt <= 5'h00;
    end else if (state == ADSP_ACTIVE && sck_fall) begin
      rx_word <= {rx_word[14:0], mosi_lvl};
      if (rx_cnt != ADSP_CNT_SAT) begin
        rx_cnt <= rx_cnt + 5'h01;
      end
    end
  end

  // Transmit side: status captured at frame start, register at the parity bit.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_word  <= 16'h0000;
      rise_cnt <= 5'h00;
      miso_out <= 1'b0;
    end else if (ss_fall) begin
      tx_word  <= {rd_value(ADSP_SYSTEM_STATUS, regs, hw_status_in), 8'h00};
      rise_cnt <= 5'h00;
    end else if (state == ADSP_ACTIVE && sck_rise) begin
      // Extra rising edges of a broken frame leave the last bit standing.
      if (rise_cnt < ADSP_FRAME_EDGES) begin
        miso_out <= tx_word[4'(15 - rise_cnt)];
        rise_cnt <= rise_cnt + 5'h01;
      end
      if (rise_cnt == ADSP_PARITY_RISE) begin
        // Read and write alike return the value before any commit.
        tx_word[7:0] <= rd_value(rx_word[4:0], regs, hw_status_in);
      end
    end
  end

  // Frame acceptance at the closing select edge.
  assign write_ok = (rx_cnt == ADSP_FRAME_EDGES)
                 && !rx_word[ADSP_DIR_BIT]
                 && !(^rx_word[ADSP_DIR_BIT:ADSP_PARITY_BIT])
                 && (rx_word[ADSP_ADDR_HI:ADSP_ADDR_LO] < 5'(NREG));

  // A commit waits here while the FIFO is full; a newer write is then dropped.
  // A new write may load in the cycle in which the old one is pushed, so the
  // set wins over the clear and no free slot is wasted.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_pend <= 1'b0;
      wr_cmd  <= '0;
    end else if (state == ADSP_ACTIVE && ss_rise && write_ok
                 && (!wr_pend || fifo_in_ready)) begin
      wr_pend     <= 1'b1;
      wr_cmd.addr <= rx_word[ADSP_ADDR_HI:ADSP_ADDR_LO];
      wr_cmd.data <= rx_word[7:0];
    end else if (wr_pend && fifo_in_ready) begin
      wr_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      frame_error_out <= 1'b0;
    end else if (state == ADSP_ACTIVE && ss_rise) begin
      frame_error_out <= (rx_cnt != ADSP_FRAME_EDGES);
    end
  end

  adsp_fifo #(
    .WIDTH (ADSP_WR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (wr_pend),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (wr_cmd),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_data)
  );

  // The analog core may hold register updates; the FIFO absorbs the backlog.
  assign fifo_out_ready = !reg_hold_in;
  assign drain          = fifo_out_valid && fifo_out_ready;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < NREG; i++) begin
        regs[i] <= ADSP_REG_RESET;
      end
    end else if (drain) begin
      case (fifo_out_data.addr)
        ADSP_WATCHDOG_CONTROL: begin
          // The enable bit is set-only; the clear bit is a pulse, never stored.
          regs[ADSP_WATCHDOG_CONTROL] <= {regs[ADSP_WATCHDOG_CONTROL][ADSP_WD_ENABLE_BIT]
                                          | fifo_out_data.data[7],
                                          fifo_out_data.data[6:5], 5'h00};
        end
        ADSP_PRODUCTION_TEST: begin
          regs[ADSP_PRODUCTION_TEST] <= regs[ADSP_PRODUCTION_TEST];
        end
        default: begin
          regs[fifo_out_data.addr] <= fifo_out_data.data;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      watchdog_clear_out <= 1'b0;
    end else begin
      watchdog_clear_out <= drain && (fifo_out_data.addr == ADSP_WATCHDOG_CONTROL)
                            && fifo_out_data.data[ADSP_WD_CLEAR_BIT];
    end
  end

  assign reg_file_out = regs;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  // These watch the filtered pin view; timing ahead of the filter is out of reach.
  a_idle_released: assert property (
    filt[2] && $past(filt[2]) |-> miso_oe_n_out
  ) else $error("data output driven while select is high");

  a_fall_drives: assert property (
    ss_fall |=> !miso_oe_n_out && state == ADSP_ACTIVE
  ) else $error("select fall did not turn the output on");

  a_miso_on_rise: assert property (
    $changed(miso_out) |-> $past(sck_rise)
  ) else $error("data output changed away from a rising clock edge");

  a_first_bit: assert property (
    sck_rise && state == ADSP_ACTIVE && rise_cnt == 5'h00
    |=> miso_out == $past(tx_word[15]) && rise_cnt == 5'h01
  ) else $error("first status bit not presented at first rising edge");

  a_sample_fall: assert property (
    $changed(rx_word) |-> $past(sck_fall) && $past(state == ADSP_ACTIVE)
  ) else $error("input shifted away from a falling clock edge");

  a_commit_count: assert property (
    $rose(wr_pend) |-> $past(rx_cnt) == ADSP_FRAME_EDGES && $past(ss_rise)
  ) else $error("write accepted without exactly sixteen edges");

  a_commit_parity: assert property (
    $rose(wr_pend) |-> !$past(rx_word[15]) && !(^$past(rx_word[15:9]))
  ) else $error("read or odd-parity frame produced a write");

  a_status_first: assert property (
    ss_fall |=> tx_word[15:8] == $past(rd_value(ADSP_SYSTEM_STATUS, regs, hw_status_in))
  ) else $error("first output byte is not the system status");

  a_parity_load: assert property (
    sck_rise && state == ADSP_ACTIVE && rise_cnt == ADSP_PARITY_RISE
    |=> tx_word[7:0] == $past(rd_value(rx_word[4:0], regs, hw_status_in))
  ) else $error("register value not captured at the parity bit");

  a_wd_clear: assert property (
    watchdog_clear_out |-> $past(drain) && $past(fifo_out_data.addr) == ADSP_WATCHDOG_CONTROL
  ) else $error("watchdog clear without a matching write");

  a_rise_releases: assert property (
    ss_rise && state == ADSP_ACTIVE |=> miso_oe_n_out && state == ADSP_IDLE
  ) else $error("select rise did not release the data output");

  a_idle_off: assert property (
    state == ADSP_IDLE && $past(state == ADSP_IDLE) |-> miso_oe_n_out
  ) else $error("data output driven outside a frame");

  a_read_no_write: assert property (
    ss_rise && state == ADSP_ACTIVE && rx_word[ADSP_DIR_BIT] && !wr_pend |=> !wr_pend
  ) else $error("read frame produced a write");

  a_count_flag: assert property (
    ss_rise && state == ADSP_ACTIVE && rx_cnt != ADSP_FRAME_EDGES |=> frame_error_out
  ) else $error("wrong edge count not flagged");

  a_count_no_write: assert property (
    ss_rise && state == ADSP_ACTIVE && rx_cnt != ADSP_FRAME_EDGES && !wr_pend |=> !wr_pend
  ) else $error("frame with a wrong edge count produced a write");

  // An accepted write must carry the address and data of its own frame.
  a_commit_fields: assert property (
    ss_rise && state == ADSP_ACTIVE && write_ok && (!wr_pend || fifo_in_ready)
    |=> wr_pend && wr_cmd.addr == $past(rx_word[ADSP_ADDR_HI:ADSP_ADDR_LO])
        && wr_cmd.data == $past(rx_word[7:0])
  ) else $error("accepted write did not carry its address and data");

  a_drain_store: assert property (
    drain && fifo_out_data.addr != ADSP_WATCHDOG_CONTROL
    && fifo_out_data.addr != ADSP_PRODUCTION_TEST
    |=> regs[$past(fifo_out_data.addr)] == $past(fifo_out_data.data)
  ) else $error("drained write did not reach its register");

  a_test_reg_fixed: assert property (
    $stable(regs[ADSP_PRODUCTION_TEST])
  ) else $error("production test register changed");

endmodule : adsp_spi_port

/* File: adsp_pkg.sv */
/*
  Shared constants and types of the analog die serial register port.
  Assumes one 100 MHz system clock; the serial link is sampled by that clock.
*/
package adsp_pkg;

  localparam int ADSP_NREG       = 18;
  localparam int ADSP_AW         = 5;
  localparam int ADSP_DW         = 8;
  localparam int ADSP_FRAME_BITS = 16;
  localparam int ADSP_FIFO_DEPTH = 8;

  // Register offsets.
  localparam logic [4:0] ADSP_SYSTEM_CONTROL       = 5'h00;
  localparam logic [4:0] ADSP_HALF_BRIDGE_OUTPUT   = 5'h01;
  localparam logic [4:0] ADSP_HIGH_SIDE_OUTPUT     = 5'h02;
  localparam logic [4:0] ADSP_HALF_BRIDGE_STATUS   = 5'h03;
  localparam logic [4:0] ADSP_HIGH_SIDE_STATUS     = 5'h04;
  localparam logic [4:0] ADSP_GLASS_DRIVER_STATUS  = 5'h05;
  localparam logic [4:0] ADSP_GLASS_DRIVER_DAC     = 5'h06;
  localparam logic [4:0] ADSP_HALL_INPUT_STATUS    = 5'h07;
  localparam logic [4:0] ADSP_ANALOG_MUX_CONTROL   = 5'h08;
  localparam logic [4:0] ADSP_INTERRUPT_MASK       = 5'h09;
  localparam logic [4:0] ADSP_INTERRUPT_FLAGS      = 5'h0a;
  localparam logic [4:0] ADSP_WATCHDOG_CONTROL     = 5'h0b;
  localparam logic [4:0] ADSP_SYSTEM_STATUS        = 5'h0c;
  localparam logic [4:0] ADSP_RESET_CAUSE_STATUS   = 5'h0d;
  localparam logic [4:0] ADSP_PRODUCTION_TEST      = 5'h0e;
  localparam logic [4:0] ADSP_TRIM_ONE             = 5'h0f;
  localparam logic [4:0] ADSP_TRIM_TWO             = 5'h10;
  localparam logic [4:0] ADSP_TRIM_THREE           = 5'h11;

  localparam logic [7:0] ADSP_REG_RESET = 8'h00;

  // Bits read back from the stored register value, index = offset.
  localparam logic [ADSP_NREG-1:0][7:0] ADSP_RD_MASK = {
    8'h00, 8'h00, 8'hc0, 8'h00, 8'h00, 8'h00, 8'he0, 8'h00, 8'hff,
    8'hff, 8'h07, 8'h3f, 8'ha0, 8'h00, 8'h80, 8'hbf, 8'hff, 8'h1f};
  // Bits that the analog core supplies live, index = offset.
  localparam logic [ADSP_NREG-1:0][7:0] ADSP_HW_MASK = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'hfb, 8'hff, 8'h00, 8'hef, 8'h00,
    8'h00, 8'h98, 8'h00, 8'h43, 8'h87, 8'h0f, 8'h00, 8'h00, 8'h80};

  // Positions inside a received 16-bit frame, MSB first.
  localparam int ADSP_DIR_BIT    = 15;
  localparam int ADSP_ADDR_HI    = 14;
  localparam int ADSP_ADDR_LO    = 10;
  localparam int ADSP_PARITY_BIT = 9;
  // Rising edge index at which the parity bit is on the line.
  localparam logic [4:0] ADSP_PARITY_RISE = 5'h06;
  localparam logic [4:0] ADSP_FRAME_EDGES = 5'h10;
  localparam logic [4:0] ADSP_CNT_SAT     = 5'h11;

  localparam int ADSP_WD_ENABLE_BIT = 7;
  localparam int ADSP_WD_CLEAR_BIT  = 0;

  typedef struct packed {
    logic [ADSP_AW-1:0] addr;
    logic [ADSP_DW-1:0] data;
  } adsp_wr_t;

  localparam int ADSP_WR_W = $bits(adsp_wr_t);

  typedef enum logic [1:0] {
    ADSP_IDLE   = 2'b01,
    ADSP_ACTIVE = 2'b10
  } adsp_state_t;

endpackage : adsp_pkg

/* File: adsp_fifo.sv */
/*
  Small synchronous FIFO of flip-flops with valid and ready on both sides.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module adsp_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count != (PW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : adsp_fifo

/* File: adsp_master_model.sv */
/*
  Behavioural serial master that stands on the far side of the register port.
  Assumes the bench calls xfer from a process timed on falling clk_in edges
  and hands it a miso level already resolved from the port's enable.
*/
`timescale 1ns/1ns
module adsp_master_model (
  input  wire logic clk_in,
  input  wire logic miso_in,
  input  wire logic miso_oe_n_in,
  output logic      select_n_out,
  output logic      sck_out,
  output logic      mosi_out
);
  // Half of the 160 ns link period at a 10 ns system clock.
  localparam int HALF = 8;

  // Idle levels follow the pull-up on select and the pull-downs on clock and data.
  initial begin
    select_n_out = 1'b1;
    sck_out      = 1'b0;
    mosi_out     = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_in);
  endtask : wait_clk

  // A count other than sixteen lets the bench send deliberately broken frames.
  task automatic xfer(input logic [15:0] tx, input int nclk,
                      output logic [15:0] rx, output logic oe_ok);
    rx    = 16'h0000;
    oe_ok = 1'b1;
    select_n_out = 1'b0;
    wait_clk(HALF);
    for (int i = 0; i < nclk; i++) begin
      sck_out  = 1'b1;
      mosi_out = (i < 16) ? tx[15 - i] : 1'b0;
      wait_clk(HALF);
      rx      = {rx[14:0], miso_in};
      oe_ok   = oe_ok & (miso_oe_n_in === 1'b0);
      sck_out = 1'b0;
      wait_clk(HALF);
    end
    select_n_out = 1'b1;
    mosi_out     = 1'b0;
    wait_clk(2 * HALF);
  endtask : xfer
endmodule : adsp_master_model

/* File: tb_top.sv */
/*
  Self-checking bench of the serial register port against a register model.
  Assumes the master model drives the link and that the design's own
  assertions watch its internal timing.
*/
`timescale 1ns/1ns
module tb_top;
  import adsp_pkg::*;

  logic                      clk_in       = 1'b0;
  logic                      resetn_in    = 1'b0;
  logic                      reg_hold_in  = 1'b0;
  logic [ADSP_NREG-1:0][7:0] hw_status_in = '0;
  logic                      select_n, sck, mosi;
  logic                      miso_out, miso_oe_n_out;
  logic                      watchdog_clear_out, frame_error_out;
  logic [ADSP_NREG-1:0][7:0] reg_file_out;
  logic                      miso_last = 1'b0;
  wire logic                 miso_line;
  int                        mismatches  = 0;
  int                        checks_done = 0;
  int                        pulses      = 0;
  logic [7:0]                model_reg [ADSP_NREG];
  adsp_wr_t                  hold_q [$];
  adsp_wr_t                  hold_w;

  always #5 clk_in = ~clk_in;

  // A released line shows the inverse of its last bit so a stale value cannot match.
  always @(posedge clk_in) if (miso_oe_n_out === 1'b0) miso_last <= miso_out;
  assign miso_line = (miso_oe_n_out === 1'b0) ? miso_out : ~miso_last;
  always @(posedge clk_in) if (watchdog_clear_out === 1'b1) pulses <= pulses + 1;

  adsp_spi_port #(.NREG(ADSP_NREG), .FIFO_DEPTH(ADSP_FIFO_DEPTH)) dut_u (
    .clk_in(clk_in), .resetn_in(resetn_in), .select_n_in(select_n),
    .serial_shift_clock_in(sck), .mosi_in(mosi), .miso_out(miso_out),
    .miso_oe_n_out(miso_oe_n_out), .hw_status_in(hw_status_in),
    .reg_hold_in(reg_hold_in), .reg_file_out(reg_file_out),
    .watchdog_clear_out(watchdog_clear_out), .frame_error_out(frame_error_out));

  adsp_master_model master_u (
    .clk_in(clk_in), .miso_in(miso_line), .miso_oe_n_in(miso_oe_n_out),
    .select_n_out(select_n), .sck_out(sck), .mosi_out(mosi));

  task automatic wrap_up;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic [7:0] read_val(input logic [4:0] a);
    if (a >= ADSP_NREG) return 8'h00;
    return (model_reg[a] & ADSP_RD_MASK[a]) | (hw_status_in[a] & ADSP_HW_MASK[a]);
  endfunction : read_val

  // The enable bit of the watchdog register can only be set, never cleared.
  function automatic void apply(input logic [4:0] a, input logic [7:0] d);
    if (a == ADSP_WATCHDOG_CONTROL) model_reg[a] = {model_reg[a][7] | d[7], d[6:0]};
    else if (a != ADSP_PRODUCTION_TEST && a < ADSP_NREG) model_reg[a] = d;
  endfunction : apply

  task automatic frame(input logic dir, input logic [4:0] addr, input logic [7:0] data,
                       input int nclk, input logic bad_par);
    logic [15:0] tx, rx, exp;
    logic        oe_ok, ok, wd;
    int          p0;
    tx  = {dir, addr, ^{dir, addr} ^ bad_par, 1'b0, data};
    exp = {read_val(ADSP_SYSTEM_STATUS), read_val(addr)};
    ok  = (nclk == 16) && !dir && !bad_par;
    wd  = ok && addr == ADSP_WATCHDOG_CONTROL && data[0] && !reg_hold_in;
    p0  = pulses;
    master_u.xfer(tx, nclk, rx, oe_ok);
    if (nclk == 16) check("rx_frame", rx, exp);
    check("frame_err", {15'h0, frame_error_out}, {15'h0, nclk != 16});
    check("oe", {14'h0, oe_ok, miso_oe_n_out}, 16'h0003);
    check("wd_pulse", 16'(pulses - p0), {15'h0, wd});
    if (ok && reg_hold_in) begin
      if (hold_q.size() < 9) hold_q.push_back({addr, data});
    end else if (ok) begin
      apply(addr, data);
    end
    for (int i = 0; i < ADSP_NREG; i++) hw_status_in[i] = 8'($urandom);
  endtask : frame

  initial begin
    repeat (100000) @(posedge clk_in);
    mismatches++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'hcd486688));
    for (int i = 0; i < ADSP_NREG; i++) model_reg[i] = 8'h00;
    repeat (8) @(negedge clk_in);
    resetn_in = 1'b1;
    check("reset_regs", {15'h0, reg_file_out === '0}, 16'h0001);
    check("reset_oe", {15'h0, miso_oe_n_out}, 16'h0001);
    repeat (4) @(negedge clk_in);
    // Every address, plus one unmapped, is written and then read with bad parity.
    for (int a = 0; a <= ADSP_NREG; a++) begin
      frame(1'b0, (a == ADSP_NREG) ? 5'h15 : 5'(a), 8'($urandom), 16, 1'b0);
      frame(1'b1, (a == ADSP_NREG) ? 5'h15 : 5'(a), 8'($urandom), 16, 1'b1);
    end
    frame(1'b0, ADSP_WATCHDOG_CONTROL, 8'h01, 16, 1'b0);
    frame(1'b0, ADSP_WATCHDOG_CONTROL, 8'h00, 16, 1'b0);
    frame(1'b0, ADSP_HALF_BRIDGE_OUTPUT, 8'ha5, 16, 1'b1);
    frame(1'b0, ADSP_HALF_BRIDGE_OUTPUT, 8'h3c, 15, 1'b0);
    frame(1'b0, ADSP_HALF_BRIDGE_OUTPUT, 8'h3c, 17, 1'b0);
    frame(1'b1, ADSP_HALF_BRIDGE_OUTPUT, 8'h00, 16, 1'b0);
    // Eight writes fill the FIFO, a ninth waits for space and a tenth is dropped.
    reg_hold_in = 1'b1;
    for (int i = 0; i < 10; i++) frame(1'b0, ADSP_HALF_BRIDGE_OUTPUT, 8'h10 + 8'(i), 16, 1'b0);
    reg_hold_in = 1'b0;
    while (hold_q.size() > 0) begin
      hold_w = hold_q.pop_front();
      apply(hold_w.addr, hold_w.data);
    end
    repeat (20) @(negedge clk_in);
    check("fifo_reg", {8'h0, reg_file_out[1]}, {8'h0, model_reg[1]});
    frame(1'b1, ADSP_HALF_BRIDGE_OUTPUT, 8'h00, 16, 1'b0);
    wrap_up();
  end
endmodule : tb_top
